// ---- verilog/load_shed_and_switch_logic.v ----
// load shedding, lookup-table logic elements and timer elements
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "load_switch_map.vh"

// Notes on behaviour
// - Each of the 16 breaker channels holds a programmable priority of high, medium or low.
// - A high-priority channel is never disabled by load shedding.
// - Medium channels are disabled when the supply falls below the medium deactivate level.
// - Medium channels are enabled again when the supply rises above the medium activate level.
// - Low channels are disabled when the supply falls below the low deactivate level.
// - Low channels are enabled again when the supply rises above the low activate level.
// - There are eight logic elements, each a three-input lookup table.
// - Inputs A, B and C of each element come from selectable internal signals.
// - Each table holds eight bits and the element output is the bit for the input pattern.
// - There are eight timers, each fed from a selectable internal signal.
// - A timer passes, delays falling edges, or delays rising edges by its programmed time.
module load_shed_and_switch_logic
#(
  parameter NCH      = 16,
  parameter NEL      = 8,
  parameter TICK_CYC = `TICK_NS / `CLK_NS
)
(
  input  wire        CLK,
  input  wire        RST_B,
  input  wire [15:0] SUPPLY_MV,
  input  wire [7:0]  EXT_SIG,
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  output reg  [15:0] CHAN_EN,
  output reg  [7:0]  LOGIC_OUT,
  output reg  [7:0]  TIMER_OUT
);

////////////////////////////////////////////////////////////////////////////////
// signal selection: 0 none, 1..8 external, 9..16 logic, 17..24 timers

  function sel_sig;
    input [4:0]  sel;
    input [23:0] pool;
    begin
      if (sel == `SEL_NONE || sel > `SEL_MAX)
        sel_sig = 1'b0;
      else
        sel_sig = pool[sel - 5'h01];
    end
  endfunction

  // true when the address falls in the eight-word window at base
  function win_hit;
    input [7:0] addr;
    input [7:0] base;
    begin
      win_hit = ((addr & `WIN_MASK) == base);
    end
  endfunction

  wire [23:0] pool = {TIMER_OUT, LOGIC_OUT, EXT_SIG};

////////////////////////////////////////////////////////////////////////////////
// registers

  reg [31:0] prio_lo_q;
  reg [31:0] prio_hi_q;
  reg [15:0] med_deact_q;
  reg [15:0] med_act_q;
  reg [15:0] low_deact_q;
  reg [15:0] low_act_q;
  reg [31:0] lut_cfg_q [0:NEL-1];
  reg [9:0]  tmr_cfg_q [0:NEL-1];
  reg [15:0] tmr_time_q [0:NEL-1];
  reg        med_on_q;
  reg        low_on_q;
  reg        med_on_d;
  reg        low_on_d;
  reg [15:0] chan_en_d;
  reg [31:0] rdata_d;
  wire [7:0] logic_d;
  wire [7:0] timer_d;
  integer    i;
  integer    n;

  // word index inside a 32-byte register window
  wire [2:0] idx = ADDR[`REG_STRIDE_SHIFT+2:`REG_STRIDE_SHIFT];

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      prio_lo_q   <= 32'h00000000;
      prio_hi_q   <= 32'h00000000;
      med_deact_q <= `RST_MED_DEACT;
      med_act_q   <= `RST_MED_ACT;
      low_deact_q <= `RST_LOW_DEACT;
      low_act_q   <= `RST_LOW_ACT;
      for (i = 0; i < NEL; i = i + 1)
      begin
        lut_cfg_q[i]  <= 32'h00000000;
        tmr_cfg_q[i]  <= 10'h000;
        tmr_time_q[i] <= 16'h0000;
      end
    end
    else if (WR)
    begin
      case (ADDR)
        `REG_PRIO_LO:   prio_lo_q   <= WDATA;
        `REG_PRIO_HI:   prio_hi_q   <= WDATA;
        `REG_MED_DEACT: med_deact_q <= WDATA[15:0];
        `REG_MED_ACT:   med_act_q   <= WDATA[15:0];
        `REG_LOW_DEACT: low_deact_q <= WDATA[15:0];
        `REG_LOW_ACT:   low_act_q   <= WDATA[15:0];
        default:
        begin
          // anything outside the windows is dropped
          if (win_hit(ADDR, `REG_LUT_BASE) && idx < NEL)
            lut_cfg_q[idx] <= WDATA & `LUT_CFG_MASK;
          if (win_hit(ADDR, `REG_TMR_BASE) && idx < NEL)
            tmr_cfg_q[idx] <= {WDATA[`TMR_TYPE_LSB+1:`TMR_TYPE_LSB], 3'h0,
                               WDATA[`TMR_SEL_LSB+4:`TMR_SEL_LSB]};
          if (win_hit(ADDR, `REG_TMR_TIME_BASE) && idx < NEL)
            tmr_time_q[idx] <= WDATA[15:0];
        end
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
// load shedding with hysteresis

  // between the two levels the state holds: that gap is the hysteresis
  always @*
  begin
    med_on_d = med_on_q;
    low_on_d = low_on_q;
    if (SUPPLY_MV < med_deact_q)
      med_on_d = 1'b0;
    else if (SUPPLY_MV > med_act_q)
      med_on_d = 1'b1;
    if (SUPPLY_MV < low_deact_q)
      low_on_d = 1'b0;
    else if (SUPPLY_MV > low_act_q)
      low_on_d = 1'b1;
  end

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      med_on_q <= 1'b1;
      low_on_q <= 1'b1;
    end
    else
    begin
      med_on_q <= med_on_d;
      low_on_q <= low_on_d;
    end
  end

  wire [63:0] prio_all = {prio_hi_q, prio_lo_q};

  // enable of one channel from its priority code; code 3 counts as high
  function chan_on;
    input [1:0] prio;
    input       med_on;
    input       low_on;
    begin
      case (prio)
        `PRIO_MED: chan_on = med_on;
        `PRIO_LOW: chan_on = low_on;
        default:   chan_on = 1'b1;
      endcase
    end
  endfunction

  always @*
  begin
    chan_en_d = 16'h0000;
    for (n = 0; n < NCH; n = n + 1)
      chan_en_d[n] = chan_on(prio_all[2*n +: 2], med_on_q, low_on_q);
  end

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      CHAN_EN <= `RST_CHAN_EN;
    else
      CHAN_EN <= chan_en_d;
  end

////////////////////////////////////////////////////////////////////////////////
// logic elements and timers

  // timer states: follow the input, or hold the old level while a delayed edge ages
  localparam [1:0] ST_FOLLOW = 2'b01;
  localparam [1:0] ST_WAIT   = 2'b10;

  genvar g;
  generate
    for (g = 0; g < NEL; g = g + 1)
    begin : elem
      wire [31:0] c   = lut_cfg_q[g];
      wire        a   = sel_sig(c[`LUT_A_LSB+4:`LUT_A_LSB], pool);
      wire        b   = sel_sig(c[`LUT_B_LSB+4:`LUT_B_LSB], pool);
      wire        cc  = sel_sig(c[`LUT_C_LSB+4:`LUT_C_LSB], pool);
      wire [2:0]  row = {a, b, cc};
      assign logic_d[g] = c[`LUT_TBL_LSB + row];

      wire [9:0]  t       = tmr_cfg_q[g];
      wire        tin     = sel_sig(t[`TMR_SEL_LSB+4:`TMR_SEL_LSB], pool);
      wire [1:0]  ty      = t[`TMR_TYPE_LSB+1:`TMR_TYPE_LSB];
      wire        cur     = TIMER_OUT[g];
      wire        delayed = (ty == `DLY_OFF && !tin) || (ty == `DLY_ON && tin);
      // prescaler counts clocks to one tick, ticks counts the delay
      reg  [1:0]  st_q;
      reg  [1:0]  st_d;
      reg  [31:0] pre_q;
      reg  [31:0] pre_d;
      reg  [15:0] ticks_q;
      reg  [15:0] ticks_d;
      reg         out_d;

      always @*
      begin
        st_d    = st_q;
        pre_d   = pre_q;
        ticks_d = ticks_q;
        out_d   = cur;
        case (st_q)
          ST_FOLLOW:
          begin
            pre_d   = 32'h00000000;
            ticks_d = 16'h0000;
            if (tin != cur && delayed)
              st_d = ST_WAIT;
            else
              out_d = tin;
          end
          ST_WAIT:
          begin
            if (tin == cur || !delayed)
            begin
              // input went back: the pending edge is dropped; type changed: the edge passes at once
              st_d  = ST_FOLLOW;
              out_d = tin;
            end
            else if (ticks_q >= tmr_time_q[g])
            begin
              st_d  = ST_FOLLOW;
              out_d = tin;
            end
            else if (pre_q == TICK_CYC - 1)
            begin
              pre_d   = 32'h00000000;
              ticks_d = ticks_q + 16'h0001;
            end
            else
              pre_d = pre_q + 32'h00000001;
          end
          default:
            st_d = ST_FOLLOW;
        endcase
      end

      always @(posedge CLK or negedge RST_B)
      begin
        if (!RST_B)
        begin
          st_q    <= ST_FOLLOW;
          pre_q   <= 32'h00000000;
          ticks_q <= 16'h0000;
        end
        else
        begin
          st_q    <= st_d;
          pre_q   <= pre_d;
          ticks_q <= ticks_d;
        end
      end

      assign timer_d[g] = out_d;
    end
  endgenerate

  // element and timer outputs leave straight from flip-flops
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      LOGIC_OUT <= 8'h00;
      TIMER_OUT <= 8'h00;
    end
    else
    begin
      LOGIC_OUT <= logic_d;
      TIMER_OUT <= timer_d;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// read path

  always @*
  begin
    rdata_d = 32'h00000000;
    case (ADDR)
      `REG_PRIO_LO:     rdata_d = prio_lo_q;
      `REG_PRIO_HI:     rdata_d = prio_hi_q;
      `REG_MED_DEACT:   rdata_d = {16'h0000, med_deact_q};
      `REG_MED_ACT:     rdata_d = {16'h0000, med_act_q};
      `REG_LOW_DEACT:   rdata_d = {16'h0000, low_deact_q};
      `REG_LOW_ACT:     rdata_d = {16'h0000, low_act_q};
      `REG_SUPPLY_MV:   rdata_d = {16'h0000, SUPPLY_MV};
      `REG_SHED_STATUS: rdata_d = {30'h00000000, low_on_q, med_on_q};
      `REG_CHAN_ENABLE: rdata_d = {16'h0000, CHAN_EN};
      `REG_SIGNALS:     rdata_d = {8'h00, pool};
      default:
      begin
        // unmapped addresses read as zero
        if (win_hit(ADDR, `REG_LUT_BASE) && idx < NEL)
          rdata_d = lut_cfg_q[idx];
        if (win_hit(ADDR, `REG_TMR_BASE) && idx < NEL)
          rdata_d = {22'h000000, tmr_cfg_q[idx]};
        if (win_hit(ADDR, `REG_TMR_TIME_BASE) && idx < NEL)
          rdata_d = {16'h0000, tmr_time_q[idx]};
      end
    endcase
  end

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= 32'h00000000;
    else if (RD)
      RDATA <= rdata_d;
    else
      RDATA <= 32'h00000000;
  end

endmodule

// ---- verilog/load_switch_map.vh ----
// register map, field layout and timing constants of the load shed and switch block
`ifndef LOAD_SWITCH_MAP_VH
`define LOAD_SWITCH_MAP_VH
// register offsets (byte addresses)
`define REG_PRIO_LO        8'h00
`define REG_PRIO_HI        8'h04
`define REG_MED_DEACT      8'h08
`define REG_MED_ACT        8'h0C
`define REG_LOW_DEACT      8'h10
`define REG_LOW_ACT        8'h14
`define REG_SUPPLY_MV      8'h18
`define REG_SHED_STATUS    8'h1C
`define REG_CHAN_ENABLE    8'h20
`define REG_SIGNALS        8'h24
`define REG_LUT_BASE       8'h40
`define REG_TMR_BASE       8'h60
`define REG_TMR_TIME_BASE  8'h80
`define REG_STRIDE_SHIFT   2
// priority codes
`define PRIO_HIGH          2'h0
`define PRIO_MED           2'h1
`define PRIO_LOW           2'h2
// delay type codes
`define DLY_NONE           2'h0
`define DLY_OFF            2'h1
`define DLY_ON             2'h2
// selector code meaning no signal selected
`define SEL_NONE           5'h00
`define SEL_MAX            5'h18
// address window of the per-element register blocks
`define WIN_MASK           8'hE0
// writable bits of a logic element config word
`define LUT_CFG_MASK       32'h1F1F1FFF
// channel enables after reset
`define RST_CHAN_EN        16'hFFFF
// logic element config fields: table [7:0], A sel [12:8], B sel [20:16], C sel [28:24]
`define LUT_TBL_LSB        0
`define LUT_A_LSB          8
`define LUT_B_LSB          16
`define LUT_C_LSB          24
// timer config fields: select [4:0], type [9:8]
`define TMR_SEL_LSB        0
`define TMR_TYPE_LSB       8
// threshold reset values in millivolts
`define RST_MED_DEACT      16'h300C
`define RST_MED_ACT        16'h3138
`define RST_LOW_DEACT      16'h3070
`define RST_LOW_ACT        16'h3200
// timer tick period in nanoseconds, and clock period in nanoseconds
`define TICK_NS            1000000
`define CLK_NS             10
`endif

// ---- bench/supply_monitor_model.sv ----
// supply voltage monitor model feeding the measured supply
`timescale 1ns/1ps
module supply_monitor_model
(
  input  wire        clk,
  input  wire        rst_b,
  input  wire [15:0] target_mv,
  output reg  [15:0] supply_mv
);
  // one sample of measurement latency
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      supply_mv <= 16'h3390;
    else
      supply_mv <= target_mv;
  end
endmodule

// ---- bench/load_shed_monitor.sv ----
// port checks of the load shed and switch block
`timescale 1ns/1ps
`include "load_switch_map.vh"
module load_shed_monitor
(
  input wire        CLK,
  input wire        RST_B,
  input wire [15:0] SUPPLY_MV,
  input wire [7:0]  ADDR,
  input wire        WR,
  input wire        RD,
  input wire [31:0] RDATA,
  input wire [15:0] CHAN_EN,
  input wire [7:0]  LOGIC_OUT,
  input wire [7:0]  TIMER_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence rd_at(logic [7:0] a);
    RD && ADDR == a;
  endsequence
  sequence quiet_low;
    (SUPPLY_MV < 16'd7000 && !WR) [*4];
  endsequence
  rst_state_a: assert property ($rose(RST_B) |-> CHAN_EN == 16'hFFFF && LOGIC_OUT == 8'h0
    && TIMER_OUT == 8'h0) else $error("outputs wrong after reset");
  shed_high_a: assert property (SUPPLY_MV > 16'd32000 |-> ##2 CHAN_EN == 16'hFFFF)
    else $error("channels not enabled at high supply");
  shed_hold_a: assert property (quiet_low |-> $stable(CHAN_EN))
    else $error("enables moved while shed");
  supply_rd_a: assert property (rd_at(`REG_SUPPLY_MV) ##0 $stable(SUPPLY_MV)
    |=> RDATA == {16'h0, $past(SUPPLY_MV)}) else $error("supply readback wrong");
  chan_rd_a: assert property (rd_at(`REG_CHAN_ENABLE) |=> RDATA == {16'h0, $past(CHAN_EN)})
    else $error("enable readback wrong");
  pool_rd_a: assert property (rd_at(`REG_SIGNALS)
    |=> RDATA[23:8] == {$past(TIMER_OUT), $past(LOGIC_OUT)}) else $error("pool readback wrong");
  unmap_rd_a: assert property (rd_at(8'hFC) |=> RDATA == 32'h0) else $error("unmapped read");
  status_rd_a: assert property (rd_at(`REG_SHED_STATUS) |=> RDATA[31:2] == 30'h0)
    else $error("status upper bits set");
  rd_idle_a: assert property (!RD |=> RDATA == 32'h0) else $error("read data without read");
endmodule
bind load_shed_and_switch_logic load_shed_monitor u_mon (.CLK(CLK), .RST_B(RST_B),
  .SUPPLY_MV(SUPPLY_MV), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .CHAN_EN(CHAN_EN),
  .LOGIC_OUT(LOGIC_OUT), .TIMER_OUT(TIMER_OUT));

// ---- bench/tb.sv ----
// self-checking bench of the load shed and switch block
`timescale 1ns/1ps
`include "load_switch_map.vh"
module tb;
  reg         clk = 0;
  reg         rst_b = 0;
  reg  [15:0] tgt = 16'h3390;
  reg  [7:0]  ext = 0;
  reg  [7:0]  addr = 0;
  reg  [31:0] wdata = 0;
  reg         wr = 0;
  reg         rd = 0;
  wire [15:0] supply;
  wire [31:0] rdata;
  wire [15:0] chan_en;
  wire [7:0]  logic_out;
  wire [7:0]  timer_out;
  integer     bad_count = 0;
  integer     cmp_count = 0;
  integer     k, v, med_on, low_on;
  reg  [31:0] prio, d, e;
  reg  [31:0] cfg [0:7];
  int         volts [$] = '{33000, 11900, 11700, 11200, 10900, 6500, 11400, 11600, 12000, 12600};
  always #5 clk = ~clk;
  supply_monitor_model u_supply_monitor_model (.clk(clk), .rst_b(rst_b), .target_mv(tgt),
    .supply_mv(supply));
  load_shed_and_switch_logic #(.TICK_CYC(4)) u_load_shed_and_switch_logic (.CLK(clk),
    .RST_B(rst_b), .SUPPLY_MV(supply), .EXT_SIG(ext), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CHAN_EN(chan_en), .LOGIC_OUT(logic_out), .TIMER_OUT(timer_out));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] s, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wreg(input [7:0] a, input [31:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rreg(input [7:0] a, output [31:0] dv);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 dv = rdata;
  endtask
  function automatic bit pick(input [4:0] s);
    pick = (s != 0 && s < 9) ? ext[s-1] : 1'b0;
  endfunction
  function automatic [7:0] lut_exp();
    for (int j = 0; j < 8; j++)
      lut_exp[j] = cfg[j][{pick(cfg[j][12:8]), pick(cfg[j][20:16]), pick(cfg[j][28:24])}];
  endfunction
  function automatic [15:0] shed_exp();
    for (int c = 0; c < 16; c++)
      shed_exp[c] = prio[2*c +: 2] == `PRIO_MED ? med_on[0] :
        prio[2*c +: 2] == `PRIO_LOW ? low_on[0] : 1'b1;
  endfunction
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    bad_count = bad_count + 1;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hBED3));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    cyc(2);
    chk({chan_en, logic_out, timer_out}, 32'hFFFF0000);
    rreg(`REG_MED_DEACT, d);
    chk(d, `RST_MED_DEACT);
    rreg(8'hFC, d);
    chk(d, 0);
    $display("test reset done");
    prio = $urandom;
    wreg(`REG_PRIO_LO, prio);
    wreg(`REG_MED_DEACT, 11000);
    wreg(`REG_MED_ACT, 11500);
    wreg(`REG_LOW_DEACT, 11800);
    wreg(`REG_LOW_ACT, 12500);
    med_on = 1;
    low_on = 1;
    foreach (volts[i])
    begin
      v = volts[i];
      if (v < 11000) med_on = 0; else if (v > 11500) med_on = 1;
      if (v < 11800) low_on = 0; else if (v > 12500) low_on = 1;
      @(posedge clk);
      tgt <= v[15:0];
      cyc(6);
      chk(chan_en, shed_exp());
      rreg(`REG_SHED_STATUS, d);
      chk(d, {low_on[0], med_on[0]});
      rreg(`REG_SUPPLY_MV, d);
      chk(d, v);
      rreg(`REG_CHAN_ENABLE, d);
      chk(d, shed_exp());
    end
    $display("test shed done");
    for (k = 0; k < 8; k++)
    begin
      cfg[k] = {3'h0, 5'($urandom % 9), 3'h0, 5'($urandom % 9), 3'h0, 5'($urandom % 9), 8'($urandom)};
      if (k == 0)
        cfg[k][28:24] = `SEL_NONE;
      wreg(`REG_LUT_BASE + 8'(4 * k), cfg[k]);
    end
    repeat (8)
    begin
      ext <= 8'($urandom);
      cyc(3);
      chk(logic_out, lut_exp());
      @(posedge clk);
    end
    $display("test logic done");
    ext <= 0;
    for (k = 0; k < 3; k++)
    begin
      wreg(`REG_TMR_BASE + 8'(4 * k), {22'h0, 2'(k), 3'h0, 5'(k + 1)});
      wreg(`REG_TMR_TIME_BASE + 8'(4 * k), 3);
    end
    for (k = 0; k < 3; k++)
    begin
      @(posedge clk);
      ext[k] <= 1'b1;
      cyc(5);
      chk(timer_out[k], k != `DLY_ON);
      cyc(20);
      chk(timer_out[k], 1);
      @(posedge clk);
      ext[k] <= 1'b0;
      cyc(5);
      chk(timer_out[k], k == `DLY_OFF);
      cyc(20);
      chk(timer_out[k], 0);
    end
    wreg(`REG_TMR_BASE + 8'h0C, {22'h000000, 2'h3, 3'h0, 5'h09});
    cyc(4);
    e = {16'h0000, lut_exp(), 8'h00};
    e[19] = e[8];
    chk(timer_out[3], e[8]);
    rreg(`REG_SIGNALS, d);
    chk(d, e);
    $display("test timer done");
    tally_and_finish();
  end
endmodule
